// File: verilog/pdcfg_pkg.sv
// Purpose: Constants and carrier types for the paged configuration bank
// Assumes: Byte-wide registers, bank nibble plus byte offset addressing
// Notes: Reserved bits are never stored and read back as zero
package pdcfg_pkg;
   // Bank nibble of an access; this value steers into the interface bank
   localparam logic [3:0] BANK_IFACE = 4'h6;

   // General register offsets
   localparam logic [7:0] OFF_IFACE_PTR_LO = 8'h03;
   localparam logic [7:0] OFF_IFACE_PTR_HI = 8'h04;
   localparam logic [7:0] OFF_PAIRING = 8'h05;
   localparam logic [7:0] OFF_ANALOG_PTR = 8'h11;

   // Master page offsets
   localparam logic [7:0] OFF_M1_CORE = 8'h20;
   localparam logic [7:0] OFF_M1_BUF = 8'h21;
   localparam logic [7:0] OFF_M2_CORE = 8'h23;
   localparam logic [7:0] OFF_M2_BUF = 8'h24;
   localparam logic [7:0] OFF_PD_SELECT = 8'h26;
   localparam logic [7:0] OFF_MASK_CTRL = 8'h55;

   // Page pointer values
   localparam logic [15:0] PAGE_MAIN_DIGITAL = 16'h6800;
   localparam logic [15:0] PAGE_IFACE_DIGITAL = 16'h6900;
   localparam logic [15:0] PAGE_IFACE_ANALOG = 16'h6a00;
   localparam logic [7:0] PAGE_MASTER = 8'h80;
   localparam logic [7:0] PAGE_CONVERTER = 8'h0f;

   // Field positions
   localparam int PAIR_BIT = 0;
   localparam int CHOICE_BIT = 5;
   localparam int MASKCTL_BIT = 4;
   localparam int CORE_A_LSB = 4;
   localparam int CORE_B_LSB = 0;
   localparam int BUF_A_LSB = 4;
   localparam int BUF_B_LSB = 6;
   localparam int CORE_W = 4;
   localparam int BUF_W = 2;

   // Reset value and stored-bit mask of buffer registers
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] BUF_KEEP = 8'hf0;

   // One register access from the serial front end
   typedef struct packed {
      logic write;
      logic [3:0] bank;
      logic [7:0] offset;
      logic [7:0] wdata;
   } req_t;

   // Power-down fields of one mask
   typedef struct packed {
      logic [3:0] core_a;
      logic [3:0] core_b;
      logic [1:0] buf_a;
      logic [1:0] buf_b;
   } pd_t;
endpackage : pdcfg_pkg

// File: verilog/powerdown_mask_select.sv
// Purpose: Picks the applied power-down mask
// Assumes: Inputs are registered by the caller
// Notes: Purely combinational; the top registers the result
`timescale 1ns/1ps
module powerdown_mask_select
   import pdcfg_pkg::*;
(
   // Both stored masks
   input wire pd_t mask1,
   input wire pd_t mask2,
   // Controls
   input wire logic mask_choice,
   input wire logic mask_control,
   // Applied fields
   output pd_t applied
);
   // Mask only acts while enabled; choice picks 1 or 2
   always_comb begin
      if (!mask_control) begin
         applied = '0;
      end else if (mask_choice) begin
         applied = mask2;
      end else begin
         applied = mask1;
      end
   end
endmodule : powerdown_mask_select

// File: verilog/paged_config_and_powerdown_masks.sv
// Purpose: Paged configuration registers, channel pairing and power-down masks
// Assumes: Requests come from serial front-end logic on the same clock
// Notes: Read data and forwarded writes appear one cycle after the request
`timescale 1ns/1ps
// Behaviour
// RULE1: The high byte of the interface page pointer is a read/write register resetting to zero.
// RULE2: Interface pointer values 6800h, 6900h and 6A00h select the three interface-bank pages.
// RULE3: With per-channel programming off, a converter write reaches both channels together.
// RULE4: With per-channel programming on, a write reaches only the selected channel.
// RULE5: The analog page pointer selects master at 80h and converter at 0Fh and resets to zero.
// RULE6: Mask 1 is the master-page pair at 20h and 21h.
// RULE7: Mask 2 is the master-page pair at 23h and 24h with the same layout.
// RULE8: The core register holds channel A in bits 7-4 and channel B in bits 3-0, reset zero.
// RULE9: The buffer register holds channel B in bits 7-6, channel A in 5-4, bits 3-0 write-only.
// RULE10: Bit 5 of master-page 26h decides which mask applies.
// RULE11: Masks take effect only as the mask-control bit at master-page 55h allows.
// RULE12: The low byte of the interface page pointer is a read/write register resetting to zero.
// RULE13: Mask choice 0 applies mask 1 and 1 applies mask 2.
// RULE14: The host writes zero to every reserved bit. The host model passes bits 7-6 of 26h through unchanged.
// RULE15: A paged register is reached only while its page pointer holds that page.
module paged_config_and_powerdown_masks
   import pdcfg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register access
   input wire logic req_valid,
   input wire req_t req,
   output logic rd_valid,
   output logic [7:0] rd_data,
   // Channel choice for per-channel writes
   input wire logic channel_select,
   // Converter page writes towards the channels
   output logic conv_wr_a,
   output logic conv_wr_b,
   // Interface bank writes
   output logic iface_wr,
   output logic [2:0] iface_page,
   // Offset and data of the forwarded write
   output logic [7:0] fwd_offset,
   output logic [7:0] fwd_wdata,
   // Applied power-down fields
   output pd_t pd_applied
);
   // True for a general register, reachable from any page
   function automatic logic is_general(input logic [7:0] off);
      return off == OFF_IFACE_PTR_LO || off == OFF_IFACE_PTR_HI ||
             off == OFF_PAIRING || off == OFF_ANALOG_PTR;
   endfunction : is_general

   // Outside the interface bank at the given offset
   function automatic logic hit(input req_t r, input logic [7:0] off);
      return r.bank != BANK_IFACE && r.offset == off;
   endfunction : hit

   // Page pointer decode: main digital, interface digital, interface analog
   function automatic logic [2:0] page_onehot(input logic [15:0] ptr);
      return {ptr == PAGE_IFACE_ANALOG, ptr == PAGE_IFACE_DIGITAL,
              ptr == PAGE_MAIN_DIGITAL};
   endfunction : page_onehot

   logic [7:0] ptr_hi_ff, nxt_ptr_hi;
   logic [7:0] ptr_lo_ff, nxt_ptr_lo;
   logic pairing_ff, nxt_pairing;
   logic [7:0] analog_ptr_ff, nxt_analog_ptr;
   logic [7:0] m1_core_ff, nxt_m1_core;
   logic [7:0] m1_buf_ff, nxt_m1_buf;
   logic [7:0] m2_core_ff, nxt_m2_core;
   logic [7:0] m2_buf_ff, nxt_m2_buf;
   logic choice_ff, nxt_choice;
   logic maskctl_ff, nxt_maskctl;
   logic rd_valid_ff, nxt_rd_valid;
   logic [7:0] rd_data_ff, nxt_rd_data;
   logic conv_wr_a_ff, nxt_conv_wr_a;
   logic conv_wr_b_ff, nxt_conv_wr_b;
   logic iface_wr_ff, nxt_iface_wr;
   logic [2:0] iface_page_ff, nxt_iface_page;
   logic [7:0] fwd_offset_ff, nxt_fwd_offset;
   logic [7:0] fwd_wdata_ff, nxt_fwd_wdata;
   pd_t pd_ff, nxt_pd;
   pd_t mask1, mask2;
   logic wr, master, conv_hit, iface_hit;

   // Access qualifiers
   assign wr = req_valid && req.write;
   assign master = analog_ptr_ff == PAGE_MASTER; // [RULE5] [RULE15]
   assign conv_hit = wr && req.bank != BANK_IFACE && !is_general(req.offset) &&
                     analog_ptr_ff == PAGE_CONVERTER; // [RULE5] [RULE15]
   assign iface_hit = wr && req.bank == BANK_IFACE &&
                      |page_onehot({ptr_hi_ff, ptr_lo_ff}); // [RULE2] [RULE15]

   // Register writes
   always_comb begin
      nxt_ptr_hi = ptr_hi_ff;
      nxt_ptr_lo = ptr_lo_ff;
      nxt_pairing = pairing_ff;
      nxt_analog_ptr = analog_ptr_ff;
      nxt_m1_core = m1_core_ff;
      nxt_m1_buf = m1_buf_ff;
      nxt_m2_core = m2_core_ff;
      nxt_m2_buf = m2_buf_ff;
      nxt_choice = choice_ff;
      nxt_maskctl = maskctl_ff;
      if (wr && hit(req, OFF_IFACE_PTR_HI)) begin
         nxt_ptr_hi = req.wdata; // [RULE1]
      end
      if (wr && hit(req, OFF_IFACE_PTR_LO)) begin
         nxt_ptr_lo = req.wdata; // [RULE12]
      end
      if (wr && hit(req, OFF_PAIRING)) begin
         nxt_pairing = req.wdata[PAIR_BIT];
      end
      if (wr && hit(req, OFF_ANALOG_PTR)) begin
         nxt_analog_ptr = req.wdata; // [RULE5]
      end
      if (wr && master) begin
         if (hit(req, OFF_M1_CORE)) nxt_m1_core = req.wdata; // [RULE6] [RULE8]
         if (hit(req, OFF_M1_BUF)) nxt_m1_buf = req.wdata & BUF_KEEP; // [RULE6] [RULE9]
         if (hit(req, OFF_M2_CORE)) nxt_m2_core = req.wdata; // [RULE7] [RULE8]
         if (hit(req, OFF_M2_BUF)) nxt_m2_buf = req.wdata & BUF_KEEP; // [RULE7] [RULE9]
         if (hit(req, OFF_PD_SELECT)) nxt_choice = req.wdata[CHOICE_BIT]; // [RULE10]
         if (hit(req, OFF_MASK_CTRL)) nxt_maskctl = req.wdata[MASKCTL_BIT]; // [RULE11]
      end
   end

   // Read back; write-only bits and unmapped offsets read zero
   always_comb begin
      nxt_rd_valid = req_valid && !req.write;
      nxt_rd_data = RST_BYTE;
      if (req_valid && !req.write && req.bank != BANK_IFACE) begin
         case (req.offset)
            OFF_IFACE_PTR_LO: nxt_rd_data = ptr_lo_ff;
            OFF_IFACE_PTR_HI: nxt_rd_data = ptr_hi_ff;
            OFF_PAIRING: nxt_rd_data[PAIR_BIT] = pairing_ff;
            OFF_ANALOG_PTR: nxt_rd_data = analog_ptr_ff;
            OFF_M1_CORE: nxt_rd_data = master ? m1_core_ff : RST_BYTE;
            OFF_M1_BUF: nxt_rd_data = master ? m1_buf_ff : RST_BYTE;
            OFF_M2_CORE: nxt_rd_data = master ? m2_core_ff : RST_BYTE;
            OFF_M2_BUF: nxt_rd_data = master ? m2_buf_ff : RST_BYTE;
            OFF_PD_SELECT: nxt_rd_data[CHOICE_BIT] = master && choice_ff;
            OFF_MASK_CTRL: nxt_rd_data[MASKCTL_BIT] = master && maskctl_ff;
            default: nxt_rd_data = RST_BYTE;
         endcase
      end
   end

   // Forwarded writes to the channels and the interface bank
   always_comb begin
      nxt_conv_wr_a = conv_hit && (!pairing_ff || !channel_select); // [RULE3] [RULE4]
      nxt_conv_wr_b = conv_hit && (!pairing_ff || channel_select); // [RULE3] [RULE4]
      nxt_iface_wr = iface_hit; // [RULE2]
      nxt_iface_page = page_onehot({ptr_hi_ff, ptr_lo_ff}); // [RULE2]
      nxt_fwd_offset = fwd_offset_ff;
      nxt_fwd_wdata = fwd_wdata_ff;
      if (conv_hit || iface_hit) begin
         nxt_fwd_offset = req.offset;
         nxt_fwd_wdata = req.wdata;
      end
   end

   // Mask field unpacking
   assign mask1 = '{core_a: m1_core_ff[CORE_A_LSB +: CORE_W], // [RULE8]
                    core_b: m1_core_ff[CORE_B_LSB +: CORE_W],
                    buf_a: m1_buf_ff[BUF_A_LSB +: BUF_W], // [RULE9]
                    buf_b: m1_buf_ff[BUF_B_LSB +: BUF_W]};
   assign mask2 = '{core_a: m2_core_ff[CORE_A_LSB +: CORE_W],
                    core_b: m2_core_ff[CORE_B_LSB +: CORE_W],
                    buf_a: m2_buf_ff[BUF_A_LSB +: BUF_W],
                    buf_b: m2_buf_ff[BUF_B_LSB +: BUF_W]};

   // Applied mask selection
   powerdown_mask_select u_sel (
      .mask1(mask1),
      .mask2(mask2),
      .mask_choice(choice_ff), // [RULE10] [RULE13]
      .mask_control(maskctl_ff), // [RULE11]
      .applied(nxt_pd)
   );

   // State registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ptr_hi_ff <= RST_BYTE;
         ptr_lo_ff <= RST_BYTE;
         pairing_ff <= 1'b0;
         analog_ptr_ff <= RST_BYTE;
         m1_core_ff <= RST_BYTE;
         m1_buf_ff <= RST_BYTE;
         m2_core_ff <= RST_BYTE;
         m2_buf_ff <= RST_BYTE;
         choice_ff <= 1'b0;
         maskctl_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= RST_BYTE;
         conv_wr_a_ff <= 1'b0;
         conv_wr_b_ff <= 1'b0;
         iface_wr_ff <= 1'b0;
         iface_page_ff <= 3'h0;
         fwd_offset_ff <= RST_BYTE;
         fwd_wdata_ff <= RST_BYTE;
         pd_ff <= '0;
      end else begin
         ptr_hi_ff <= nxt_ptr_hi;
         ptr_lo_ff <= nxt_ptr_lo;
         pairing_ff <= nxt_pairing;
         analog_ptr_ff <= nxt_analog_ptr;
         m1_core_ff <= nxt_m1_core;
         m1_buf_ff <= nxt_m1_buf;
         m2_core_ff <= nxt_m2_core;
         m2_buf_ff <= nxt_m2_buf;
         choice_ff <= nxt_choice;
         maskctl_ff <= nxt_maskctl;
         rd_valid_ff <= nxt_rd_valid;
         rd_data_ff <= nxt_rd_data;
         conv_wr_a_ff <= nxt_conv_wr_a;
         conv_wr_b_ff <= nxt_conv_wr_b;
         iface_wr_ff <= nxt_iface_wr;
         iface_page_ff <= nxt_iface_page;
         fwd_offset_ff <= nxt_fwd_offset;
         fwd_wdata_ff <= nxt_fwd_wdata;
         pd_ff <= nxt_pd;
      end
   end

   // Outputs straight from flops
   assign rd_valid = rd_valid_ff;
   assign rd_data = rd_data_ff;
   assign conv_wr_a = conv_wr_a_ff;
   assign conv_wr_b = conv_wr_b_ff;
   assign iface_wr = iface_wr_ff;
   assign iface_page = iface_page_ff;
   assign fwd_offset = fwd_offset_ff;
   assign fwd_wdata = fwd_wdata_ff;
   assign pd_applied = pd_ff;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_conv_write;
      req_valid && req.write && req.bank != BANK_IFACE && !is_general(req.offset) &&
      analog_ptr_ff == PAGE_CONVERTER;
   endsequence
   sequence s_master_m1_core_write;
      req_valid && req.write && master && req.bank != BANK_IFACE &&
      req.offset == OFF_M1_CORE;
   endsequence

   property p_ptr_hi_load;
      wr && hit(req, OFF_IFACE_PTR_HI) |=> ptr_hi_ff == $past(req.wdata);
   endproperty
   a_ptr_hi_load: assert property (p_ptr_hi_load) else $error("high pointer not set"); // [RULE1]
   property p_ptr_lo_read;
      req_valid && !req.write && hit(req, OFF_IFACE_PTR_LO) |=> rd_valid && rd_data == ptr_lo_ff;
   endproperty
   a_ptr_lo_read: assert property (p_ptr_lo_read) else $error("low pointer misread"); // [RULE12]
   property p_iface_gate;
      req_valid && req.write && req.bank == BANK_IFACE && {ptr_hi_ff, ptr_lo_ff} !=
      PAGE_MAIN_DIGITAL && {ptr_hi_ff, ptr_lo_ff} != PAGE_IFACE_DIGITAL &&
      {ptr_hi_ff, ptr_lo_ff} != PAGE_IFACE_ANALOG |=> !iface_wr;
   endproperty
   a_iface_gate: assert property (p_iface_gate) else $error("interface write off page"); // [RULE2]
   property p_pair_both;
      s_conv_write ##0 !pairing_ff |=> conv_wr_a && conv_wr_b;
   endproperty
   a_pair_both: assert property (p_pair_both) else $error("paired write missed one"); // [RULE3]
   property p_single_chan;
      s_conv_write ##0 pairing_ff |=> (conv_wr_a != conv_wr_b) &&
      conv_wr_b == $past(channel_select);
   endproperty
   a_single_chan: assert property (p_single_chan) else $error("single write misrouted"); // [RULE4]
   property p_m1_core_fields;
      s_master_m1_core_write ##1 (maskctl_ff && !choice_ff) |=>
      pd_applied.core_a == $past(req.wdata[7:4], 2) &&
      pd_applied.core_b == $past(req.wdata[3:0], 2);
   endproperty
   a_m1_core_fields: assert property (p_m1_core_fields) else $error("mask 1 core bad"); // [RULE8]
   property p_buf_reserved_zero;
      req_valid && !req.write && hit(req, OFF_M2_BUF) |=> rd_data[3:0] == 4'h0;
   endproperty
   a_buf_reserved_zero: assert property (p_buf_reserved_zero) // [RULE9]
      else $error("reserved bits read set");
   property p_choice_mask2;
      maskctl_ff && choice_ff |=> pd_applied.buf_b == $past(m2_buf_ff[7:6]) &&
      pd_applied.buf_a == $past(m2_buf_ff[5:4]);
   endproperty
   a_choice_mask2: assert property (p_choice_mask2) else $error("mask 2 not applied"); // [RULE13]
   property p_maskctl_off;
      !maskctl_ff [*2] |-> pd_applied == '0;
   endproperty
   a_maskctl_off: assert property (p_maskctl_off) else $error("mask leaked while off"); // [RULE11]
   property p_page_gate;
      req_valid && req.write && req.bank != BANK_IFACE && req.offset == OFF_M1_CORE &&
      analog_ptr_ff != PAGE_MASTER |=> $stable(m1_core_ff);
   endproperty
   a_page_gate: assert property (p_page_gate) else $error("write reached closed page"); // [RULE15]
endmodule : paged_config_and_powerdown_masks

// File: dv/cfg_host_model.sv
// Purpose: Serial configuration host that turns bench commands into register requests
// Assumes: One command per cycle at most, bench drives commands at the rising edge
// Notes: Reserved bits are cleared before a write leaves the host, except bits 7-6 of the 26h select register
`timescale 1ns/1ps
module cfg_host_model
   import pdcfg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Commands from the bench
   input wire logic cmd_valid,
   input wire req_t cmd,
   // Requests towards the device
   output logic req_valid,
   output req_t req
);
   // Reserved positions of a general or master register
   function automatic logic [7:0] rsvd(input req_t c);
      if (c.bank == BANK_IFACE) return 8'h00;
      case (c.offset)
         OFF_PAIRING: return 8'hfe;
         OFF_M1_BUF, OFF_M2_BUF: return 8'h0f;
         OFF_PD_SELECT: return 8'h1f;
         OFF_MASK_CTRL: return 8'hef;
         default: return 8'h00;
      endcase
   endfunction : rsvd

   // Issue one request a cycle; idle request lines toggle so stale values never look valid
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         req_valid <= 1'b0;
         req <= '0;
      end else if (cmd_valid) begin
         req_valid <= 1'b1;
         req <= '{write: cmd.write, bank: cmd.bank, offset: cmd.offset,
                  wdata: cmd.wdata & ~rsvd(cmd)};
      end else begin
         req_valid <= 1'b0;
         req <= ~req;
      end
   end
   // Page pointers are loaded by the bench through this host before paged accesses
endmodule : cfg_host_model

// File: dv/paged_config_and_powerdown_masks_tb_top.sv
// Purpose: Self-checking bench for the paged configuration bank
// Assumes: Host model feeds the device; a reference model predicts every output
// Notes: Directed corners first, then seeded random traffic, then a reset in mid-run
`timescale 1ns/1ps
module paged_config_and_powerdown_masks_tb_top
   import pdcfg_pkg::*;
;
   logic clock = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, req_valid, channel_select = 1'b0;
   logic rd_valid, conv_wr_a, conv_wr_b, iface_wr;
   logic [7:0] rd_data, fwd_offset, fwd_wdata;
   logic [2:0] iface_page;
   req_t cmd = '0, req;
   pd_t pd_applied, e_pd;
   int n_fail = 0, n_checks = 0, i, k;
   logic [7:0] sh [0:255];
   logic [7:0] o, e_rd, e_off, e_dat;
   logic [15:0] ptr;
   logic hit, e_rdv, e_wa, e_wb, e_if;
   logic [2:0] e_pg;
   logic [31:0] r;
   localparam logic [7:0] OFS [16] = '{8'h03, 8'h04, 8'h05, 8'h11, 8'h20, 8'h21, 8'h23, 8'h24,
      8'h26, 8'h55, 8'h30, 8'h00, 8'h7f, 8'h03, 8'h04, 8'h11};
   localparam logic [7:0] DAT [8] = '{8'h68, 8'h69, 8'h6a, 8'h00, 8'h80, 8'h0f, 8'h10, 8'h20};

   always #2.5 clock = ~clock;

   cfg_host_model i_host (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .req_valid(req_valid), .req(req));
   paged_config_and_powerdown_masks i_dut (.clock(clock), .nrst(nrst), .req_valid(req_valid),
      .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .channel_select(channel_select),
      .conv_wr_a(conv_wr_a), .conv_wr_b(conv_wr_b), .iface_wr(iface_wr),
      .iface_page(iface_page), .fwd_offset(fwd_offset), .fwd_wdata(fwd_wdata),
      .pd_applied(pd_applied));

   // Register classes and stored-bit masks
   function automatic logic gen(input logic [7:0] a);
      return a inside {OFF_IFACE_PTR_LO, OFF_IFACE_PTR_HI, OFF_PAIRING, OFF_ANALOG_PTR};
   endfunction : gen
   function automatic logic mst(input logic [7:0] a);
      return a inside {OFF_M1_CORE, OFF_M1_BUF, OFF_M2_CORE, OFF_M2_BUF, OFF_PD_SELECT,
         OFF_MASK_CTRL};
   endfunction : mst
   function automatic logic [7:0] keep(input logic [7:0] a);
      case (a)
         OFF_PAIRING: return 8'h01;
         OFF_M1_BUF, OFF_M2_BUF: return BUF_KEEP;
         OFF_PD_SELECT: return 8'h20;
         OFF_MASK_CTRL: return 8'h10;
         default: return 8'hff;
      endcase
   endfunction : keep
   function automatic pd_t mask_of(input logic [7:0] c, input logic [7:0] b);
      return {c[7:4], c[3:0], b[5:4], b[7:6]};
   endfunction : mask_of
   function automatic logic [2:0] page_of(input logic [15:0] p);
      return {p == PAGE_IFACE_ANALOG, p == PAGE_IFACE_DIGITAL, p == PAGE_MAIN_DIGITAL};
   endfunction : page_of

   // Reference model sampling the device inputs at the same edge
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         foreach (sh[j]) sh[j] = 8'h00;
         {e_rdv, e_wa, e_wb, e_if, e_rd, e_off, e_dat, e_pg, e_pd} = '0;
      end else begin
         ptr = {sh[OFF_IFACE_PTR_HI], sh[OFF_IFACE_PTR_LO]};
         e_pg = page_of(ptr);
         e_pd = !sh[OFF_MASK_CTRL][MASKCTL_BIT] ? '0 : sh[OFF_PD_SELECT][CHOICE_BIT] ?
            mask_of(sh[OFF_M2_CORE], sh[OFF_M2_BUF]) : mask_of(sh[OFF_M1_CORE], sh[OFF_M1_BUF]);
         {e_wa, e_wb, e_if, e_rd} = '0;
         e_rdv = req_valid && !req.write;
         if (req_valid) begin
            o = req.offset;
            hit = req.bank != BANK_IFACE &&
               (gen(o) || (mst(o) && sh[OFF_ANALOG_PTR] == PAGE_MASTER));
            if (!req.write) e_rd = hit ? sh[o] : 8'h00;
            else if (hit) sh[o] = req.wdata & keep(o);
            else if (req.bank != BANK_IFACE && sh[OFF_ANALOG_PTR] == PAGE_CONVERTER) begin
               e_wa = !sh[OFF_PAIRING][PAIR_BIT] || !channel_select;
               e_wb = !sh[OFF_PAIRING][PAIR_BIT] || channel_select;
               {e_off, e_dat} = {o, req.wdata};
            end else if (req.bank == BANK_IFACE && e_pg != 3'b000) begin
               e_if = 1'b1;
               {e_off, e_dat} = {o, req.wdata};
            end
         end
      end
   end

   // Compare every output mid-cycle
   always @(negedge clock) begin
      if (nrst) begin
         check(rd_valid, e_rdv);
         check(rd_data, e_rd);
         check(conv_wr_a, e_wa);
         check(conv_wr_b, e_wb);
         check(iface_wr, e_if);
         check(iface_page, e_pg);
         check({fwd_offset, fwd_wdata}, {e_off, e_dat});
         check(pd_applied, e_pd);
      end
   end

   // Random channel choice every cycle
   always @(posedge clock) channel_select <= 1'($urandom);

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic issue(input logic w, input logic [3:0] b, input logic [7:0] a, d);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= '{write: w, bank: b, offset: a, wdata: d};
   endtask : issue
   task automatic wr(input logic [7:0] a, d);
      issue(1'b1, 4'h0, a, d);
   endtask : wr
   task automatic rd_all();
      foreach (OFS[j]) issue(1'b0, 4'h0, OFS[j], 8'h00);
   endtask : rd_all
   task automatic idle(input int n);
      repeat (n) @(posedge clock) cmd_valid <= 1'b0;
   endtask : idle
   task automatic do_reset();
      idle(1);
      nrst <= 1'b0;
      idle(8);
      nrst <= 1'b1;
   endtask : do_reset

   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Watchdog
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end

   initial begin
      r = $urandom(86);
      do_reset();
      // Reset values, then masks under every choice and control setting
      rd_all();
      wr(OFF_ANALOG_PTR, PAGE_MASTER);
      rd_all();
      wr(OFF_M1_CORE, 8'ha5);
      wr(OFF_M1_BUF, 8'h90);
      wr(OFF_M2_CORE, 8'h3c);
      wr(OFF_M2_BUF, 8'h60);
      for (k = 0; k < 4; k++) begin
         wr(OFF_MASK_CTRL, k[1] ? 8'h10 : 8'h00);
         wr(OFF_PD_SELECT, k[0] ? 8'h20 : 8'h00);
         idle(2);
      end
      // Master register unreachable from another analog page
      wr(OFF_ANALOG_PTR, 8'h00);
      wr(OFF_M1_CORE, 8'hff);
      rd_all();
      // Converter writes back to back, paired then per channel
      wr(OFF_ANALOG_PTR, PAGE_CONVERTER);
      for (k = 0; k < 8; k++) begin
         if (k % 4 == 0) wr(OFF_PAIRING, 8'(k / 4));
         wr(8'(8'h30 + k), 8'($urandom));
      end
      // Interface pages and two pointer values outside them
      for (k = 0; k < 5; k++) begin
         wr(OFF_IFACE_PTR_HI, 8'(8'h68 + k % 4));
         wr(OFF_IFACE_PTR_LO, k == 4 ? 8'h01 : 8'h00);
         issue(1'b1, BANK_IFACE, 8'(8'h10 + k), 8'(8'h5a + k));
         issue(1'b0, BANK_IFACE, 8'h10, 8'h00);
      end
      // Seeded random traffic with random gaps
      for (i = 0; i < 3000; i++) begin
         r = $urandom;
         issue(r[0], r[1] ? BANK_IFACE : r[5:2], OFS[r[9:6]], r[10] ? DAT[r[13:11]] : r[31:24]);
         if (r[14]) idle(r[16:15]);
      end
      // Reset in mid-run clears everything again
      do_reset();
      rd_all();
      wr(OFF_ANALOG_PTR, PAGE_MASTER);
      rd_all();
      idle(4);
      give_verdict();
   end
endmodule : paged_config_and_powerdown_masks_tb_top
